// File: logic/mclr_config_regs.sv
// global configuration, write lock and adjustment delay registers
//
// What this block does
// - start set: monitor, use programmed limits
// - start clear: default limits, keep programmed values
// - start bit read-only once locked
// - lock writes once; lockables frozen until power-off
// - ready bit set when powered, read-only
// - full-speed drives fans, resets 0, never locked
// - bit 4 reserved, reads zero
// - spin-up mode holds PWM high whole timeout
// - timeout-off bit disables bus timeout, lockable
// - supply scale bit: 1 is 5 V, 0 is 3.3 V
// - configuration register resets to 0x00
// - dynamic control two register resets to 0x00
// - delay code sets decrease and increase cycles
// - remote two code split across two registers
`timescale 1ns/1ps
module mclr_config_regs
  import mclr_pkg::*;
(
  input wire logic clock, // system clock, 100 MHz
  input wire logic rst, // power-on reset, async, active high
  input wire logic wr_en, // register write strobe
  input wire logic [7:0] wr_addr, // register write offset
  input wire logic [7:0] wr_data, // register write data
  input wire logic rd_en, // register read strobe
  input wire logic [7:0] rd_addr, // register read offset
  output logic [7:0] rd_data, // read data, one cycle after rd_en
  output logic rd_valid, // read data valid pulse
  input wire logic powered_up, // analog power-good level, asynchronous
  input wire logic remote_two_delay_msb, // top delay bit from first dynamic register
  input wire logic cycle_done, // monitoring cycle completed pulse
  input wire logic [2:0] adjust_up, // per channel: pending adjustment raises
  input wire logic [2:0] adjust_taken, // per channel: threshold just adjusted
  output logic [2:0] adjust_due, // per channel: delay has elapsed
  output logic run_monitoring, // monitoring and PWM enabled
  output logic use_programmed_limits, // 1 programmed limits, 0 defaults
  output logic lock_active, // lockable registers frozen
  output logic all_fans_max, // force every fan to full speed
  output logic spinup_pulse_mode_off, // spin-up holds PWM high for timeout
  output logic bus_timeout_off, // suppress bus timeout
  output logic supply_5v_scale, // 1 scale supply as 5 V, 0 as 3.3 V
  output logic [2:0] remote_one_adjust_delay, // remote one delay code
  output logic [2:0] local_adjust_delay, // local delay code
  output logic [2:0] remote_two_adjust_delay // remote two delay code
);

  // ----------------------------------------------------------------
  // power-good synchroniser
  // ----------------------------------------------------------------
  logic pg_meta_reg;
  logic pg_sync_reg;

  // first stage feeds only the second stage
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pg_meta_reg <= 1'b0;
      pg_sync_reg <= 1'b0;
    end else begin
      pg_meta_reg <= powered_up;
      pg_sync_reg <= pg_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // configuration state
  // ----------------------------------------------------------------
  logic start_reg, start_next;
  logic lock_reg, lock_next;
  logic ready_reg, ready_next;
  logic all_fans_max_reg, all_fans_max_next;
  logic spin_reg, spin_next;
  logic tmo_reg, tmo_next;
  logic supply_reg, supply_next;
  logic [7:0] dyn_reg, dyn_next;
  logic cfg_wr;
  logic dyn_wr;

  assign cfg_wr = wr_en && (wr_addr == MCLR_CFG1_OFFSET);
  assign dyn_wr = wr_en && (wr_addr == MCLR_DYN2_OFFSET);

  // lock is judged on the old value, so the write that sets it still
  // lands its other fields; later writes change only the full-speed and spin-up bits
  always_comb begin
    start_next = start_reg;
    lock_next = lock_reg;
    all_fans_max_next = all_fans_max_reg;
    spin_next = spin_reg;
    tmo_next = tmo_reg;
    supply_next = supply_reg;
    dyn_next = dyn_reg;
    ready_next = ready_reg | pg_sync_reg;
    if (cfg_wr) begin
      all_fans_max_next = wr_data[MCLR_CFG_ALL_FANS_MAX_BIT];
      spin_next = wr_data[MCLR_CFG_SPIN_BIT];
      if (!lock_reg) begin
        start_next = wr_data[MCLR_CFG_START_BIT];
        lock_next = wr_data[MCLR_CFG_LOCK_BIT];
        tmo_next = wr_data[MCLR_CFG_TMO_BIT];
        supply_next = wr_data[MCLR_CFG_SUPPLY_BIT];
      end
    end
    if (dyn_wr && !lock_reg) begin
      dyn_next = wr_data;
    end
  end

  // only power-on reset reopens the lock
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      start_reg <= MCLR_CFG1_RESET[MCLR_CFG_START_BIT];
      lock_reg <= MCLR_CFG1_RESET[MCLR_CFG_LOCK_BIT];
      ready_reg <= MCLR_CFG1_RESET[MCLR_CFG_READY_BIT];
      all_fans_max_reg <= MCLR_CFG1_RESET[MCLR_CFG_ALL_FANS_MAX_BIT];
      spin_reg <= MCLR_CFG1_RESET[MCLR_CFG_SPIN_BIT];
      tmo_reg <= MCLR_CFG1_RESET[MCLR_CFG_TMO_BIT];
      supply_reg <= MCLR_CFG1_RESET[MCLR_CFG_SUPPLY_BIT];
      dyn_reg <= MCLR_DYN2_RESET;
    end else begin
      start_reg <= start_next;
      lock_reg <= lock_next;
      ready_reg <= ready_next;
      all_fans_max_reg <= all_fans_max_next;
      spin_reg <= spin_next;
      tmo_reg <= tmo_next;
      supply_reg <= supply_next;
      dyn_reg <= dyn_next;
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  logic [7:0] rd_data_reg, rd_data_next;
  logic rd_valid_reg, rd_valid_next;
  logic [7:0] cfg_view;

  // reserved bit 4 is wired to zero and ignores writes
  always_comb begin
    cfg_view = 8'h00;
    cfg_view[MCLR_CFG_START_BIT] = start_reg;
    cfg_view[MCLR_CFG_LOCK_BIT] = lock_reg;
    cfg_view[MCLR_CFG_READY_BIT] = ready_reg;
    cfg_view[MCLR_CFG_ALL_FANS_MAX_BIT] = all_fans_max_reg;
    cfg_view[MCLR_CFG_RES_BIT] = 1'b0;
    cfg_view[MCLR_CFG_SPIN_BIT] = spin_reg;
    cfg_view[MCLR_CFG_TMO_BIT] = tmo_reg;
    cfg_view[MCLR_CFG_SUPPLY_BIT] = supply_reg;
    rd_valid_next = rd_en;
    rd_data_next = rd_data_reg;
    if (rd_en) begin
      case (rd_addr)
        MCLR_CFG1_OFFSET: rd_data_next = cfg_view;
        MCLR_DYN2_OFFSET: rd_data_next = dyn_reg;
        default: rd_data_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rd_data_reg <= 8'h00;
      rd_valid_reg <= 1'b0;
    end else begin
      rd_data_reg <= rd_data_next;
      rd_valid_reg <= rd_valid_next;
    end
  end

  assign rd_data = rd_data_reg;
  assign rd_valid = rd_valid_reg;

  // ----------------------------------------------------------------
  // control outputs
  // ----------------------------------------------------------------
  // programmed limits stay in their registers; only the selection flips
  assign run_monitoring = start_reg;
  assign use_programmed_limits = start_reg;
  assign lock_active = lock_reg;
  assign all_fans_max = all_fans_max_reg;
  assign spinup_pulse_mode_off = spin_reg;
  assign bus_timeout_off = tmo_reg;
  assign supply_5v_scale = supply_reg;
  assign remote_one_adjust_delay = dyn_reg[MCLR_DYN_R1_LSB +: 3];
  assign local_adjust_delay = dyn_reg[MCLR_DYN_LOCAL_LSB +: 3];
  assign remote_two_adjust_delay = {remote_two_delay_msb, dyn_reg[MCLR_DYN_R2_LSB +: 2]};

  // ----------------------------------------------------------------
  // adjustment delay timers, one per channel
  // ----------------------------------------------------------------
  logic [2:0] chan_code [MCLR_CHANNELS];

  assign chan_code[0] = local_adjust_delay;
  assign chan_code[1] = remote_one_adjust_delay;
  assign chan_code[2] = remote_two_adjust_delay;

  for (genvar ch = 0; ch < MCLR_CHANNELS; ch++) begin : g_timer
    mclr_adjust_timer u_timer (
      .clock(clock),
      .rst(rst),
      .cycle_done(cycle_done),
      .delay_code(chan_code[ch]),
      .adjust_up(adjust_up[ch]),
      .adjust_taken(adjust_taken[ch]),
      .adjust_due(adjust_due[ch])
    );
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_cfg_read;
    rd_en && rd_addr == MCLR_CFG1_OFFSET;
  endsequence

  sequence s_answer_cfg;
    rd_valid && rd_data == $past(cfg_view);
  endsequence

  a_lock_sticky: assert property (lock_reg |=> lock_reg)
    else $error("lock bit cleared without power cycle");
  a_start_frozen: assert property (lock_reg |=> start_reg == $past(start_reg))
    else $error("start bit changed while locked");
  a_dyn_frozen: assert property (lock_reg |=> dyn_reg == $past(dyn_reg))
    else $error("dynamic control register changed while locked");
  a_lockables_frozen: assert property (lock_reg |=> $stable(tmo_reg) && $stable(supply_reg))
    else $error("lockable configuration bit changed while locked");
  a_all_fans_max_open: assert property (cfg_wr && lock_reg
      |=> all_fans_max == $past(wr_data[MCLR_CFG_ALL_FANS_MAX_BIT]))
    else $error("full-speed bit refused a write");
  a_ready_rises: assert property (pg_sync_reg |=> ready_reg ##1 ready_reg)
    else $error("ready bit not held after power good");
  a_ready_no_write: assert property (!ready_reg && !pg_sync_reg |=> !ready_reg)
    else $error("ready bit set without power good");
  a_cfg_read: assert property (s_cfg_read |=> s_answer_cfg ##0 !rd_data[4])
    else $error("configuration read returned wrong value");
  a_unmapped_zero: assert property (rd_en && rd_addr != MCLR_CFG1_OFFSET
      && rd_addr != MCLR_DYN2_OFFSET |=> rd_valid && rd_data == 8'h00)
    else $error("unmapped read not zero");
  a_start_limits: assert property (cfg_wr && !lock_reg
      |=> run_monitoring == $past(wr_data[MCLR_CFG_START_BIT])
      && use_programmed_limits == run_monitoring)
    else $error("start bit and limit select disagree");

endmodule : mclr_config_regs

// File: shared/mclr_pkg.sv
// constants shared by the monitor configuration and lock register bank
package mclr_pkg;

  // ----------------------------------------------------------------
  // register offsets and power-on values
  // ----------------------------------------------------------------
  localparam logic [7:0] MCLR_DYN2_OFFSET = 8'h37;
  localparam logic [7:0] MCLR_CFG1_OFFSET = 8'h40;
  localparam logic [7:0] MCLR_DYN2_RESET = 8'h00;
  localparam logic [7:0] MCLR_CFG1_RESET = 8'h00;

  // ----------------------------------------------------------------
  // global_configuration_one field positions
  // ----------------------------------------------------------------
  localparam int MCLR_CFG_START_BIT = 0;
  localparam int MCLR_CFG_LOCK_BIT = 1;
  localparam int MCLR_CFG_READY_BIT = 2;
  localparam int MCLR_CFG_ALL_FANS_MAX_BIT = 3;
  localparam int MCLR_CFG_RES_BIT = 4;
  localparam int MCLR_CFG_SPIN_BIT = 5;
  localparam int MCLR_CFG_TMO_BIT = 6;
  localparam int MCLR_CFG_SUPPLY_BIT = 7;

  // ----------------------------------------------------------------
  // dynamic_threshold_control_two field positions
  // ----------------------------------------------------------------
  localparam int MCLR_DYN_R1_LSB = 0;
  localparam int MCLR_DYN_LOCAL_LSB = 3;
  localparam int MCLR_DYN_R2_LSB = 6;

  // ----------------------------------------------------------------
  // adjustment delay timing, in monitoring cycles
  // ----------------------------------------------------------------
  localparam int MCLR_DELAY_W = 11;
  localparam int MCLR_CHANNELS = 3;
  localparam logic [10:0] MCLR_DEC_BASE = 11'h004;
  localparam logic [10:0] MCLR_INC_BASE = 11'h008;
  localparam logic [10:0] MCLR_COUNT_MAX = 11'h7ff;

  // length of one adjustment delay for a code and a direction
  function automatic logic [10:0] mclr_delay_len(input logic [2:0] code, input logic up);
    logic [10:0] base;
    base = up ? MCLR_INC_BASE : MCLR_DEC_BASE;
    mclr_delay_len = base << code;
  endfunction : mclr_delay_len

endpackage : mclr_pkg

// File: logic/mclr_adjust_timer.sv
// adjustment delay timer for one threshold control channel
`timescale 1ns/1ps
module mclr_adjust_timer
  import mclr_pkg::*;
(
  input wire logic clock, // system clock
  input wire logic rst, // async reset, active high
  input wire logic cycle_done, // one monitoring cycle completed
  input wire logic [2:0] delay_code, // adjustment delay code
  input wire logic adjust_up, // pending adjustment raises threshold
  input wire logic adjust_taken, // threshold adjusted, restart timer
  output logic adjust_due // delay elapsed, adjustment allowed
);

  logic [10:0] count_reg;
  logic [10:0] count_next;
  logic due_reg;
  logic due_next;
  logic [10:0] len;

  // ----------------------------------------------------------------
  // cycle counter
  // ----------------------------------------------------------------
  // saturate so a long wait never wraps back to a short delay
  always_comb begin
    len = mclr_delay_len(delay_code, adjust_up);
    count_next = count_reg;
    if (adjust_taken) begin
      count_next = 11'h000;
    end else if (cycle_done && count_reg != MCLR_COUNT_MAX) begin
      count_next = count_reg + 11'h001;
    end
    due_next = !adjust_taken && (count_next >= len);
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      count_reg <= 11'h000;
      due_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      due_reg <= due_next;
    end
  end

  assign adjust_due = due_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_restart_clears: assert property (adjust_taken |=> !adjust_due && count_reg == 11'h000)
    else $error("timer did not restart after adjustment");
  // the flag is registered, so it answers to the code and direction of the cycle before
  a_due_length: assert property (adjust_due |->
      count_reg >= $past(mclr_delay_len(delay_code, adjust_up)))
    else $error("adjustment due before delay elapsed");

endmodule : mclr_adjust_timer

// File: test/mclr_loop_model.sv
// partner model of the fan control loop: monitoring cycle pulses and threshold updates
`timescale 1ns/1ps
module mclr_loop_model (
  input wire logic clock, // system clock
  input wire logic rst, // async reset, active high
  input wire logic run, // produce monitoring cycles
  input wire logic [2:0] adjust_due, // per channel: adjustment allowed
  output logic cycle_done, // one pulse every third clock while running
  output logic [2:0] adjust_taken // per channel: threshold adjusted
);
  logic [1:0] phase_reg;

  // ------------------------------------------------------------
  // cycle pulses and adjustment handshake
  // ------------------------------------------------------------
  // two idle clocks between pulses let the timer's registered flag settle first
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      phase_reg <= 2'h0;
      cycle_done <= 1'b0;
      adjust_taken <= 3'h0;
    end else begin
      phase_reg <= (phase_reg == 2'h2 || !run) ? 2'h0 : phase_reg + 2'h1;
      cycle_done <= run && (phase_reg == 2'h2);
      adjust_taken <= adjust_due & ~adjust_taken; // adjust as soon as allowed
    end
  end
endmodule : mclr_loop_model

// File: test/mclr_config_regs_tb.sv
// self-checking bench for the configuration and lock register bank
`timescale 1ns/1ps
module mclr_config_regs_tb;
  import mclr_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic wr_en = 1'b0;
  logic [7:0] wr_addr = 8'h00;
  logic [7:0] wr_data = 8'h00;
  logic rd_en = 1'b0;
  logic [7:0] rd_addr = 8'h00;
  logic powered_up = 1'b0;
  logic msb = 1'b0;
  logic run = 1'b0;
  logic [2:0] up = 3'h0;
  logic [7:0] rd_data;
  logic rd_valid, cycle_done, run_mon, limits, lock, fans, spin, tmo, supply, prev;
  logic [2:0] taken, due, r1, loc, r2;
  logic [11:0] seen;
  logic [7:0] outs;
  int fail_count = 0;
  int compares = 0;

  // outputs packed in register bit order; ready and reserved positions stay zero
  assign outs = {supply, tmo, spin, 1'b0, fans, 1'b0, lock, run_mon};

  always #5 clock = ~clock;

  mclr_config_regs u_mclr_config_regs (.clock(clock), .rst(rst), .wr_en(wr_en),
    .wr_addr(wr_addr), .wr_data(wr_data), .rd_en(rd_en), .rd_addr(rd_addr),
    .rd_data(rd_data), .rd_valid(rd_valid), .powered_up(powered_up),
    .remote_two_delay_msb(msb), .cycle_done(cycle_done), .adjust_up(up),
    .adjust_taken(taken), .adjust_due(due), .run_monitoring(run_mon),
    .use_programmed_limits(limits), .lock_active(lock), .all_fans_max(fans),
    .spinup_pulse_mode_off(spin), .bus_timeout_off(tmo), .supply_5v_scale(supply),
    .remote_one_adjust_delay(r1), .local_adjust_delay(loc),
    .remote_two_adjust_delay(r2));

  mclr_loop_model u_mclr_loop_model (.clock(clock), .rst(rst), .run(run),
    .adjust_due(due), .cycle_done(cycle_done), .adjust_taken(taken));

  // ------------------------------------------------------------
  // independent count of cycles since the last local adjustment
  // ------------------------------------------------------------
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      seen <= 12'h000;
      prev <= 1'b0;
    end else begin
      prev <= due[0];
      if (taken[0]) seen <= 12'h000;
      else if (cycle_done) seen <= seen + 12'h001;
    end
  end

  // ------------------------------------------------------------
  // access tasks and comparisons
  // ------------------------------------------------------------
  task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    wr_en <= 1'b1;
    wr_addr <= a;
    wr_data <= d;
    @(posedge clock);
    wr_en <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock);
    rd_en <= 1'b1;
    rd_addr <= a;
    @(posedge clock);
    rd_en <= 1'b0;
    #1;
    chk("rd_valid", 12'h001, {11'h000, rd_valid});
    chk("rd_data", {4'h0, e}, {4'h0, rd_data});
  endtask : rd

  // written value shows on the outputs one cycle after the write
  task automatic chk_out(input logic [7:0] e);
    #1;
    chk("outputs", {4'h0, e}, {4'h0, outs});
    chk("limits", {11'h000, e[0]}, {11'h000, limits});
  endtask : chk_out

  // bounded wait for the local delay to elapse, then compare the cycles counted
  task automatic wait_due(input logic [11:0] e);
    int n;
    n = 0;
    do begin
      @(posedge clock);
      #1;
      n++;
    end while (!(due[0] === 1'b1 && prev === 1'b0) && n < 5000);
    if (n >= 5000) report_and_stop(1);
    chk("delay_cycles", e, seen);
  endtask : wait_due

  task automatic report_and_stop(input bit hung);
    if (hung) fail_count++;
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : report_and_stop

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    rd(MCLR_CFG1_OFFSET, MCLR_CFG1_RESET);
    rd(MCLR_DYN2_OFFSET, MCLR_DYN2_RESET);
    rd(8'h55, 8'h00);
    chk_out(8'h00);
    @(posedge clock);
    powered_up <= 1'b1;
    repeat (4) @(posedge clock);
    rd(MCLR_CFG1_OFFSET, 8'h04);
    wr(MCLR_CFG1_OFFSET, 8'h14);
    rd(MCLR_CFG1_OFFSET, 8'h04);
    $display("test reset and ready done");
    // every code in both directions; decrease first, then increase, for each code
    @(posedge clock);
    run <= 1'b1;
    for (int c = 0; c < 8; c++) begin
      for (int u = 0; u < 2; u++) begin
        @(posedge clock);
        up <= {3{u[0]}};
        wr(MCLR_DYN2_OFFSET, {2'b00, c[2:0], 3'b000});
        wait_due((u[0] ? 12'h008 : 12'h004) << c);
      end
    end
    @(posedge clock);
    run <= 1'b0;
    $display("test adjustment delay done");
    for (int m = 0; m < 2; m++) begin
      @(posedge clock);
      msb <= m[0];
      wr(MCLR_DYN2_OFFSET, 8'hd7);
      // the write lands on the edge the task returns at, so look just after it
      #1;
      chk("delays", {3'h0, m[0], 2'b11, 3'b010, 3'b111}, {3'h0, r2, loc, r1});
    end
    rd(MCLR_DYN2_OFFSET, 8'hd7);
    $display("test delay code split done");
    wr(MCLR_CFG1_OFFSET, 8'he9);
    chk_out(8'he9);
    rd(MCLR_CFG1_OFFSET, 8'hed);
    wr(MCLR_CFG1_OFFSET, 8'h00);
    chk_out(8'h00);
    rd(MCLR_DYN2_OFFSET, 8'hd7);
    $display("test start and modes done");
    wr(MCLR_CFG1_OFFSET, 8'h43);
    chk_out(8'h43);
    wr(MCLR_CFG1_OFFSET, 8'h28);
    chk_out(8'h6b);
    rd(MCLR_CFG1_OFFSET, 8'h6f);
    wr(MCLR_CFG1_OFFSET, 8'h80);
    chk_out(8'h43);
    wr(MCLR_DYN2_OFFSET, 8'h00);
    rd(MCLR_DYN2_OFFSET, 8'hd7);
    @(posedge clock);
    rst <= 1'b1;
    powered_up <= 1'b0;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    rd(MCLR_CFG1_OFFSET, 8'h00);
    chk_out(8'h00);
    $display("test lock done");
    report_and_stop(0);
  end
endmodule : mclr_config_regs_tb
